/* File: sccw_cmd.sv */
// command decoder and wait/request pin control
//
// Contract
// - crc field 00 does nothing
// - crc field 01, receiver disable or sdlc crc start reset receive crc
// - crc field 10 resets transmit crc; channel reset does not
// - crc field 11 clears eom latch; underrun then appends crc
// - sdlc abort-on-underrun sends abort and flag instead of crc
// - eom latch sets when crc starts; reset accepted only while transmitter on
// - transmitter off: latch kept, ext interrupt raised if allowed
// - command 000 does nothing
// - command 001 adds eight to the pointer in the same byte
// - command 010 re-arms latched external status
// - persisting second status change interrupts again after re-arm
// - command 011 in sdlc sends ones, flushes buffer, sets eom
// - command 100 re-arms first-character receive interrupt
// - command 101 clears tx pending until char load or crc sent
// - command 110 resets receive errors; held data released
// - command 111 clears highest in-service flag
// - low three bits select registers 0-7, or 8-15 with point high
// - mode bit 7 zero holds pin inactive: high or floating
// - request drives low when ready; wait drives low on early access
// - mode bit 5 selects receive or transmit buffer tracking
// - request only asserted while not selected; deferred past cycle
// - request on transmit pulses low one cycle at crc end
`timescale 1ns/100ps
`default_nettype none

module sccw_cmd
    import sccw_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // host register write port, already decoded for this channel
    input wire logic wr_cmd,
    input wire logic wr_mode,
    input wire logic [7:0] wr_data,
    input wire logic bus_selected,
    input wire logic cpu_rd_data,
    input wire logic cpu_wr_data,
    // channel state
    input wire sccw_pkg::sccw_chan_t chan,
    // actions and status
    output sccw_pkg::sccw_act_t act,
    output logic [3:0] reg_ptr,
    output logic eom_latch,
    output logic tx_int_blocked,
    output logic abort_ones,
    // wait/request pin
    output logic waitreq_out,
    output logic waitreq_oe
);
    import sccw_pkg::*;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    sccw_crc_t crc_f;
    sccw_cmd_t cmd_f;
    logic [7:0] mode_q;
    logic [3:0] ptr_q;
    logic eom_q;
    logic txblk_q;
    logic rx_en_q;
    sccw_abort_t ab_q;
    logic [3:0] ab_cnt_q;

    assign crc_f = sccw_crc_t'(wr_data[CRC_MSB:CRC_LSB]);
    assign cmd_f = sccw_cmd_t'(wr_data[CMD_MSB:CMD_LSB]);

    // ------------------------------------------------------------
    // mode and pointer registers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
            mode_q <= XMODE_RESET;
        else if (wr_mode)
            mode_q <= wr_data;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            ptr_q <= PTR_RESET;
        else if (wr_cmd)
        begin
            // null command leaves only pointer bits acting
            if (cmd_f == SCCW_CMD_HIGH)
                ptr_q <= {1'b0, wr_data[PTR_MSB:PTR_LSB]} + PTR_HIGH_ADD;
            else
                ptr_q <= {1'b0, wr_data[PTR_MSB:PTR_LSB]};
        end
    end
    assign reg_ptr = ptr_q;

    // ------------------------------------------------------------
    // underrun/eom latch
    // ------------------------------------------------------------
    logic eom_clr_cmd;
    assign eom_clr_cmd = wr_cmd && crc_f == SCCW_CRC_EOM;

    always_ff @(posedge clk)
    begin
        if (rst)
            eom_q <= 1'b1;
        else if (chan.crc_tx_start || ab_q == SCCW_DONE)
            eom_q <= 1'b1;
        else if (eom_clr_cmd && chan.tx_enabled)
            eom_q <= 1'b0;
    end
    assign eom_latch = eom_q;

    // ------------------------------------------------------------
    // transmit interrupt suppression
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
            txblk_q <= 1'b0;
        else if (wr_cmd && cmd_f == SCCW_CMD_TXPEND)
            txblk_q <= 1'b1;
        else if (chan.tx_char_loaded || chan.crc_tx_done)
            txblk_q <= 1'b0;
    end
    assign tx_int_blocked = txblk_q;

    // ------------------------------------------------------------
    // abort sequencer, gray path idle-ones-done
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ab_q <= SCCW_IDLE;
            ab_cnt_q <= 4'h0;
        end
        else
        begin
            case (ab_q)
                SCCW_IDLE:
                begin
                    if (wr_cmd && cmd_f == SCCW_CMD_ABORT && chan.sdlc_mode)
                    begin
                        ab_q <= SCCW_ONES;
                        ab_cnt_q <= ABORT_ONES;
                    end
                end
                SCCW_ONES:
                begin
                    ab_cnt_q <= ab_cnt_q - 4'h1;
                    if (ab_cnt_q == 4'h1)
                        ab_q <= SCCW_DONE;
                end
                SCCW_DONE:
                    ab_q <= SCCW_IDLE;
                default:
                    ab_q <= SCCW_IDLE;
            endcase
        end
    end
    assign abort_ones = ab_q == SCCW_ONES;

    // receiver enable edge, for crc init on disable
    always_ff @(posedge clk)
    begin
        if (rst)
            rx_en_q <= 1'b0;
        else
            rx_en_q <= chan.rx_enabled;
    end

    // ------------------------------------------------------------
    // action pulses
    // ------------------------------------------------------------
    always_comb
    begin
        act = '0;
        if (wr_cmd)
        begin
            // crc null raises no crc init here; receiver disable or sdlc crc start still set rx_crc_init below
            act.rx_crc_init = crc_f == SCCW_CRC_RX;
            act.tx_crc_init = crc_f == SCCW_CRC_TX;
            act.ext_rearm = cmd_f == SCCW_CMD_EXT;
            act.flush_tx = cmd_f == SCCW_CMD_ABORT && chan.sdlc_mode;
            act.rx_rearm = cmd_f == SCCW_CMD_RXNEXT && chan.first_char_mode;
            act.tx_int_clear = cmd_f == SCCW_CMD_TXPEND;
            act.err_reset = cmd_f == SCCW_CMD_ERR;
            act.ius_clear = cmd_f == SCCW_CMD_IUS;
            act.ext_eom_irq = eom_clr_cmd && !chan.tx_enabled
                && (!chan.ext_pending || cmd_f == SCCW_CMD_EXT);
        end
        if ((rx_en_q && !chan.rx_enabled) || chan.sdlc_mode && chan.crc_tx_start)
            act.rx_crc_init = 1'b1;
        if (chan.tx_underrun && !eom_q)
        begin
            if (chan.sdlc_mode && chan.abort_on_underrun)
                act.send_abort_flag = 1'b1;
            else
                act.append_crc = 1'b1;
        end
        act.send_abort = ab_q == SCCW_ONES;
    end

    // ------------------------------------------------------------
    // wait/request pin
    // ------------------------------------------------------------
    logic buf_ready;
    logic req_int;
    logic req_d;
    logic req_q;
    logic crc_pulse_q;
    logic wait_act;

    // rx: data waiting; tx: room in buffer
    assign buf_ready = mode_q[XM_ON_RX] ? chan.rx_char_avail : chan.tx_buf_empty;
    assign req_int = buf_ready && !bus_selected;

    // held while selected so a cycle in progress is never interrupted
    assign req_d = bus_selected ? req_q : req_int;

    always_ff @(posedge clk)
    begin
        if (rst)
            req_q <= 1'b0;
        else
            req_q <= req_d && !bus_selected;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            crc_pulse_q <= 1'b0;
        else
            crc_pulse_q <= chan.crc_tx_done && !mode_q[XM_ON_RX]
                && (chan.sdlc_mode || chan.sync_mode);
    end

    // wait only during the offending cpu access
    assign wait_act = mode_q[XM_ON_RX] ? (cpu_rd_data && !chan.rx_char_avail)
                                       : (cpu_wr_data && !chan.tx_buf_empty);

    always_comb
    begin
        waitreq_out = 1'b1;
        waitreq_oe = 1'b0;
        if (mode_q[XM_REQ_FN])
        begin
            // request mode always drives, high when idle
            waitreq_oe = 1'b1;
            // gated by select as well, since req_q lags a new bus cycle by one edge
            if (mode_q[XM_WR_EN])
                waitreq_out = !((req_q || crc_pulse_q) && !bus_selected);
        end
        else if (mode_q[XM_WR_EN] && wait_act)
        begin
            waitreq_out = 1'b0;
            waitreq_oe = 1'b1;
        end
    end

endmodule // sccw_cmd

`default_nettype wire

/* File: sccw_pkg.sv */
// shared constants and carriers for the command and wait/request block
package sccw_pkg;

    // command register fields
    localparam int CRC_MSB = 7;
    localparam int CRC_LSB = 6;
    localparam int CMD_MSB = 5;
    localparam int CMD_LSB = 3;
    localparam int PTR_MSB = 2;
    localparam int PTR_LSB = 0;
    localparam logic [3:0] PTR_HIGH_ADD = 4'h8;

    // transfer mode register fields
    localparam int XM_WR_EN = 7;
    localparam int XM_REQ_FN = 6;
    localparam int XM_ON_RX = 5;
    localparam logic [7:0] XMODE_RESET = 8'h00;
    localparam logic [3:0] PTR_RESET = 4'h0;

    // abort length in ones; eight to thirteen allowed, we send eight
    localparam logic [3:0] ABORT_ONES = 4'h8;

    typedef enum logic [1:0] {
        SCCW_CRC_NULL = 2'h0,
        SCCW_CRC_RX = 2'h1,
        SCCW_CRC_TX = 2'h2,
        SCCW_CRC_EOM = 2'h3
    } sccw_crc_t;

    typedef enum logic [2:0] {
        SCCW_CMD_NULL = 3'h0,
        SCCW_CMD_HIGH = 3'h1,
        SCCW_CMD_EXT = 3'h2,
        SCCW_CMD_ABORT = 3'h3,
        SCCW_CMD_RXNEXT = 3'h4,
        SCCW_CMD_TXPEND = 3'h5,
        SCCW_CMD_ERR = 3'h6,
        SCCW_CMD_IUS = 3'h7
    } sccw_cmd_t;

    // state reported by the surrounding channel logic
    typedef struct packed {
        logic tx_enabled;
        logic rx_enabled;
        logic sdlc_mode;
        logic sync_mode;
        logic abort_on_underrun;
        logic first_char_mode;
        logic special_only_mode;
        logic tx_underrun;
        logic crc_tx_start;
        logic crc_tx_done;
        logic tx_char_loaded;
        logic tx_buf_empty;
        logic rx_char_avail;
        logic ext_pending;
    } sccw_chan_t;

    // actions toward the channel logic, one cycle each except send_abort, held through the ones
    typedef struct packed {
        logic rx_crc_init;
        logic tx_crc_init;
        logic append_crc;
        logic send_abort_flag;
        logic send_abort;
        logic flush_tx;
        logic ext_rearm;
        logic ext_eom_irq;
        logic rx_rearm;
        logic tx_int_clear;
        logic err_reset;
        logic ius_clear;
    } sccw_act_t;

    typedef enum logic [1:0] {
        SCCW_IDLE = 2'b00,
        SCCW_ONES = 2'b01,
        SCCW_DONE = 2'b11
    } sccw_abort_t;

endpackage

/* File: sccw_cmd_asserts.sv */
// concurrent checks on the command decoder ports
`timescale 1ns/100ps
`default_nettype none
module sccw_cmd_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // host and channel inputs
    input wire logic wr_cmd,
    input wire logic wr_mode,
    input wire logic [7:0] wr_data,
    input wire logic bus_selected,
    input wire sccw_pkg::sccw_chan_t chan,
    // block outputs
    input wire sccw_pkg::sccw_act_t act,
    input wire logic [3:0] reg_ptr,
    input wire logic eom_latch,
    input wire logic tx_int_blocked,
    input wire logic abort_ones,
    input wire logic waitreq_out,
    input wire logic waitreq_oe
);
    import sccw_pkg::*;
    logic [7:0] mode_q;
    logic [2:0] cmd;
    logic [1:0] crc;
    assign cmd = wr_data[CMD_MSB:CMD_LSB];
    assign crc = wr_data[CRC_MSB:CRC_LSB];
    // mirror of the mode register, which the block does not expose
    always_ff @(posedge clk)
    begin
        if (rst)
            mode_q <= XMODE_RESET;
        else if (wr_mode)
            mode_q <= wr_data;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_eom_clr;
        wr_cmd && crc == 2'h3 && chan.tx_enabled && !chan.crc_tx_start;
    endsequence
    sequence s_ones;
        abort_ones [*8];
    endsequence
    property p_null;
        wr_cmd && wr_data[7:3] == 5'h00 && !chan.crc_tx_start && !abort_ones
            |-> !act.tx_crc_init ##1 $stable(eom_latch);
    endproperty
    a_null: assert property (p_null) else $error("null command had an effect");
    property p_crc_tx;
        wr_cmd && crc == 2'h2 |-> act.tx_crc_init;
    endproperty
    a_crc_tx: assert property (p_crc_tx) else $error("tx crc init missing");
    property p_eom_clr;
        s_eom_clr |=> !eom_latch;
    endproperty
    a_eom_clr: assert property (p_eom_clr) else $error("eom latch not cleared");
    property p_abort_flag;
        chan.tx_underrun && !eom_latch && chan.sdlc_mode && chan.abort_on_underrun
            |-> act.send_abort_flag && !act.append_crc;
    endproperty
    a_abort_flag: assert property (p_abort_flag) else $error("abort flag missing");
    property p_eom_hold;
        wr_cmd && crc == 2'h3 && !chan.tx_enabled && (!chan.ext_pending || cmd == 3'h2)
            |-> act.ext_eom_irq ##1 $stable(eom_latch);
    endproperty
    a_eom_hold: assert property (p_eom_hold) else $error("eom with tx off wrong");
    property p_ptr;
        wr_cmd |=> reg_ptr == {$past(cmd) == 3'h1, $past(wr_data[PTR_MSB:PTR_LSB])};
    endproperty
    a_ptr: assert property (p_ptr) else $error("pointer wrong");
    property p_abort;
        wr_cmd && cmd == 3'h3 && chan.sdlc_mode |-> act.flush_tx ##[0:1] s_ones;
    endproperty
    a_abort: assert property (p_abort) else $error("abort ones wrong");
    property p_txpend;
        wr_cmd && cmd == 3'h5 && !chan.tx_char_loaded |-> act.tx_int_clear ##1 tx_int_blocked;
    endproperty
    a_txpend: assert property (p_txpend) else $error("tx pending not blocked");
    property p_idle;
        !mode_q[XM_WR_EN] |-> (mode_q[XM_REQ_FN] ? waitreq_oe && waitreq_out : !waitreq_oe);
    endproperty
    a_idle: assert property (p_idle) else $error("pin not inactive");
    property p_sel;
        bus_selected && mode_q[XM_WR_EN] && mode_q[XM_REQ_FN] |-> waitreq_out;
    endproperty
    a_sel: assert property (p_sel) else $error("request while selected");
    property p_pulse;
        mode_q[7:5] == 3'h6 && chan.crc_tx_done && chan.sdlc_mode && !bus_selected
            |-> ##[1:2] !waitreq_out;
    endproperty
    a_pulse: assert property (p_pulse) else $error("crc end pulse missing");
endmodule // sccw_cmd_asserts
bind sccw_cmd sccw_cmd_asserts chk (.clk, .rst, .wr_cmd, .wr_mode, .wr_data, .bus_selected,
    .chan, .act, .reg_ptr, .eom_latch, .tx_int_blocked, .abort_ones, .waitreq_out, .waitreq_oe);
`default_nettype wire

/* File: sccw_dma_model.sv */
// dma controller model watching the wait/request pin
`timescale 1ns/100ps
`default_nettype none
module sccw_dma_model (
    // clock and pin
    input wire logic clk,
    input wire logic pin_out,
    input wire logic pin_oe,
    // seen level and count of driven-low cycles
    output logic pin_lvl,
    output int low_cycles = 0
);
    logic last_q = 1'b1;
    // a floating pin shows the inverse of its last value, never a settled level
    assign pin_lvl = pin_oe ? pin_out : ~last_q;
    always @(posedge clk)
    begin
        last_q <= pin_lvl;
        if (pin_oe && !pin_out)
            low_cycles <= low_cycles + 1;
    end
endmodule // sccw_dma_model
`default_nettype wire

/* File: serial_ctrl_command_wait_request_tb.sv */
// testbench for the command decoder and wait/request pin
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); end end
module serial_ctrl_command_wait_request_tb;
    import sccw_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr_cmd = 1'b0;
    logic wr_mode = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic bus_selected = 1'b0;
    logic cpu_rd_data = 1'b0;
    logic cpu_wr_data = 1'b0;
    sccw_chan_t chan = '0;
    sccw_chan_t nx = '0;
    logic c_nx = 1'b0;
    logic m_nx = 1'b0;
    logic [7:0] d_nx = 8'h00;
    logic [2:0] h_nx = 3'h0;
    sccw_act_t act;
    logic [3:0] reg_ptr;
    logic eom_latch, tx_int_blocked, abort_ones, waitreq_out, waitreq_oe, pin_lvl;
    int miscompares = 0;
    int num_checks = 0;
    int low_cycles;
    initial forever #50 clk = ~clk;
    // tasks stage values at the falling edge; they reach the block here
    always @(posedge clk)
    begin
        chan <= nx;
        wr_cmd <= c_nx;
        wr_mode <= m_nx;
        wr_data <= d_nx;
        {bus_selected, cpu_rd_data, cpu_wr_data} <= h_nx;
    end
    sccw_cmd dut (.clk, .rst, .wr_cmd, .wr_mode, .wr_data, .bus_selected, .cpu_rd_data,
        .cpu_wr_data, .chan, .act, .reg_ptr, .eom_latch, .tx_int_blocked, .abort_ones,
        .waitreq_out, .waitreq_oe);
    sccw_dma_model dma (.clk, .pin_out(waitreq_out), .pin_oe(waitreq_oe), .pin_lvl, .low_cycles);
    task step;
        @(negedge clk);
        c_nx = 1'b0;
        m_nx = 1'b0;
        nx.tx_underrun = 1'b0;
        nx.crc_tx_start = 1'b0;
        nx.crc_tx_done = 1'b0;
        nx.tx_char_loaded = 1'b0;
    endtask
    task go(input logic m, input logic [7:0] d);
        c_nx = !m;
        m_nx = m;
        d_nx = d;
        step;
    endtask
    task t_reset;
        `CHK({reg_ptr, eom_latch, tx_int_blocked, waitreq_oe}, {PTR_RESET, 3'h4})
        $display("reset test done");
    endtask
    task t_ptr;
        go(1'b0, 8'h09);
        go(1'b0, 8'h05);
        `CHK(reg_ptr, 4'h9)
        step;
        `CHK(reg_ptr, 4'h5)
        $display("pointer test done");
    endtask
    task t_crc;
        nx.tx_enabled = 1'b1;
        for (int c = 0; c < 4; c++)
        begin
            go(1'b0, 8'(c << 6));
            `CHK({act.rx_crc_init, act.tx_crc_init}, {c == 1, c == 2})
        end
        step;
        `CHK(eom_latch, 1'b0)
        nx.tx_underrun = 1'b1;
        step;
        `CHK(act.append_crc, 1'b1)
        nx.sdlc_mode = 1'b1;
        nx.abort_on_underrun = 1'b1;
        nx.tx_underrun = 1'b1;
        step;
        `CHK({act.send_abort_flag, act.append_crc}, 2'h2)
        nx.crc_tx_start = 1'b1;
        nx.tx_enabled = 1'b0;
        step;
        step;
        `CHK(eom_latch, 1'b1)
        go(1'b0, 8'hC0);
        `CHK(act.ext_eom_irq, 1'b1)
        step;
        `CHK(eom_latch, 1'b1)
        $display("crc test done");
    endtask
    task t_cmds;
        logic [5:0] got;
        nx.first_char_mode = 1'b1;
        for (int k = 0; k < 8; k++)
        begin
            go(1'b0, 8'(k << 3));
            got = {act.ext_rearm, act.flush_tx, act.rx_rearm, act.tx_int_clear, act.err_reset,
                act.ius_clear};
            `CHK(got, 6'(128 >> k))
        end
        step;
        `CHK(tx_int_blocked, 1'b1)
        nx.tx_char_loaded = 1'b1;
        step;
        step;
        `CHK(tx_int_blocked, 1'b0)
        $display("command test done");
    endtask
    task t_wait;
        int l0;
        go(1'b1, 8'h40);
        step;
        `CHK({waitreq_oe, pin_lvl}, 2'h3)
        nx.tx_buf_empty = 1'b1;
        go(1'b1, 8'hC0);
        step;
        `CHK({waitreq_oe, pin_lvl}, 2'h2)
        h_nx = 3'h4;
        step;
        step;
        `CHK(pin_lvl, 1'b1)
        h_nx = 3'h0;
        go(1'b1, 8'hE0);
        step;
        step;
        `CHK(pin_lvl, 1'b1)
        nx.rx_char_avail = 1'b1;
        step;
        step;
        `CHK(pin_lvl, 1'b0)
        nx.tx_buf_empty = 1'b0;
        h_nx = 3'h5;
        go(1'b1, 8'h80);
        step;
        `CHK({waitreq_oe, waitreq_out}, 2'h2)
        h_nx = 3'h0;
        step;
        step;
        `CHK(waitreq_oe, 1'b0)
        go(1'b1, 8'hC0);
        step;
        l0 = low_cycles;
        nx.crc_tx_done = 1'b1;
        repeat (4) step;
        `CHK(low_cycles - l0, 1)
        $display("wait/request test done");
    endtask
    task wrap_up;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        step;
        t_reset;
        t_ptr;
        t_crc;
        t_cmds;
        t_wait;
        wrap_up;
    end
    initial
    begin
        #100000;
        miscompares++;
        wrap_up;
    end
endmodule // serial_ctrl_command_wait_request_tb
`default_nettype wire
